// >>> dv/osc_pins_model.sv
// oscillator pins: crystal and 32k source
// assumes clk much faster; crystal still while disabled
`timescale 1ns/10ps
`default_nettype none
module osc_pins_model #(
    parameter int HS_HALF  = 2,
    parameter int AUX_HALF = 3
) (
    input wire logic clk,
    input wire logic hsRun,
    output logic     hsOscPin = 1'b0,
    output logic     auxOscPin = 1'b0
);
    int hsN = 0;
    int auxN = 0;
    always @(posedge clk) begin
        auxN <= (auxN == AUX_HALF - 1) ? 0 : auxN + 1;
        if (auxN == AUX_HALF - 1) auxOscPin <= ~auxOscPin;
        hsN <= (hsRun !== 1'b1 || hsN == HS_HALF - 1) ? 0 : hsN + 1;
        if (hsRun === 1'b1 && hsN == HS_HALF - 1) hsOscPin <= ~hsOscPin;
    end
endmodule // osc_pins_model
`default_nettype wire

// >>> dv/system_clock_power_mode_ctrl_asserts.sv
// assertions on the mode controller's top ports
// assumes one clk domain, synchronous rst
`timescale 1ns/10ps
`default_nettype none
module clk_mode_asserts (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // watched ports
    input wire logic                   auxOscPin,
    input wire logic                   haltReq,
    input wire logic                   wakeReq,
    input wire logic                   cpuClkEn_q,
    input wire logic                   periphClkEn_q,
    input wire logic                   auxClkEn_q,
    input wire logic                   hsOscRun_q,
    input wire clk_mode_pkg::op_mode_t mode_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic parked = mode_q inside {clk_mode_pkg::MODE_IDLE0, clk_mode_pkg::MODE_SLEEP1};
    wire logic stopped = parked || mode_q == clk_mode_pkg::MODE_IDLE1;
    logic [15:0] gap_q;
    // cycles since the last peripheral tick in idle1
    always_ff @(posedge clk) begin
        if (rst || periphClkEn_q || mode_q != clk_mode_pkg::MODE_IDLE1) gap_q <= 16'h0000;
        else gap_q <= gap_q + 16'h0001;
    end
    chk_no_sleep0: assert property (mode_q != clk_mode_pkg::MODE_SLEEP0)
        else $error("sleep0 entered");
    chk_halt_enters: assert property (haltReq && !stopped |-> ##2 stopped)
        else $error("halt ignored");
    chk_cpu_stops: assert property (stopped [*4] |-> !cpuClkEn_q)
        else $error("cpu tick while halted");
    chk_idle0_quiet: assert property (parked [*4] |-> !periphClkEn_q)
        else $error("periph tick while parked");
    chk_osc_parked: assert property (parked [*2] |-> !hsOscRun_q)
        else $error("hs oscillator left on");
    chk_idle1_periph: assert property (gap_q < 16'h07D0)
        else $error("idle1 periph stalled");
    chk_aux_ticks: assert property ($rose(auxOscPin) && !$past(rst, 4) |-> ##[3:5] auxClkEn_q)
        else $error("aux tick missing");
    chk_halt_holds: assert property (stopped && !wakeReq && !$past(wakeReq) |=> stopped)
        else $error("left halt without wake");
    cov_idle0: cover property (mode_q == clk_mode_pkg::MODE_IDLE0);
    cov_idle1: cover property (mode_q == clk_mode_pkg::MODE_IDLE1);
    cov_sleep1: cover property (mode_q == clk_mode_pkg::MODE_SLEEP1);
    cov_slow: cover property (mode_q == clk_mode_pkg::MODE_SLOW);
endmodule // clk_mode_asserts
bind system_clock_power_mode_ctrl clk_mode_asserts chk_i (.clk(clk), .rst(rst),
    .auxOscPin(auxOscPin), .haltReq(haltReq), .wakeReq(wakeReq), .cpuClkEn_q(cpuClkEn_q),
    .periphClkEn_q(periphClkEn_q), .auxClkEn_q(auxClkEn_q), .hsOscRun_q(hsOscRun_q),
    .mode_q(mode_q));
`default_nettype wire

// >>> dv/test_system_clock_power_mode_ctrl.sv
// bench: register bus, divider, slow and halt modes
// assumes crystal source, one hs tick per 4 clk
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_power_mode_ctrl;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, halt = 1'b0, wake = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dato;
    logic        ack, cpuEn, perEn, auxEn, hsRun, hsPin, auxPin;
    clk_mode_pkg::op_mode_t mode;
    int errTotal = 0, samplesChecked = 0, ctl, n, i, k;
    initial forever #4 clk = ~clk;
    osc_pins_model osc_pins_model_i (.clk(clk), .hsRun(hsRun), .hsOscPin(hsPin), .auxOscPin(auxPin));
    system_clock_power_mode_ctrl system_clock_power_mode_ctrl_i (.clk(clk), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .hsOscPin(hsPin), .auxOscPin(auxPin),
        .cfgHsSrcRc(1'b0), .haltReq(halt), .wakeReq(wake), .lowVoltEvent(1'b0),
        .voltCtrlBadEvent(1'b0), .wdogCtrlEvent(1'b0), .cpuClkEn_q(cpuEn),
        .periphClkEn_q(perEn), .auxClkEn_q(auxEn), .hsOscRun_q(hsRun), .mode_q(mode));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) errTotal++;
        rdat = dato;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic count_ticks(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge clk);
            if (cpuEn === 1'b1) c++;
        end
    endtask
    task automatic wait_mode(input clk_mode_pkg::op_mode_t e, input int lim);
        for (int t = 0; t < lim && mode !== e; t++) @(posedge clk);
        check("mode", {29'h0, mode}, {29'h0, e});
    endtask
    task automatic pulse(input bit w);
        halt <= !w;
        wake <= w;
        @(posedge clk);
        halt <= 1'b0;
        wake <= 1'b0;
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #800000;
        errTotal++;
        close_out;
    end
    initial begin
        void'($urandom(84950));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 8'h00, 0); check("control", rdat, 32'h03);
        bus(0, 8'h04, 0); check("ext", rdat, 32'h00);
        bus(0, 8'h08, 0); check("unmapped", rdat, 32'h00);
        repeat (6500) @(posedge clk);
        bus(0, 8'h00, 0); check("ready", rdat, 32'h0F);
        $display("reset and ready test done");
        // k 1: select bit; 2..7: divider code
        for (k = 1; k < 8; k++) begin
            ctl = (k == 1) ? 32'h03 : ((k << 5) | 32'h02 | (($urandom() & 1) << 4));
            bus(1, 8'h00, ctl);
            bus(0, 8'h00, 0); check("ctl rb", rdat, ctl | 32'h0C);
            repeat (600) @(posedge clk);
            n = (k == 1) ? 1024 : (1024 >> (8 - k));
            count_ticks(4096, i); check("rate", i >= n - 1 && i <= n + 1, 1);
        end
        $display("divider test done");
        bus(1, 8'h00, 32'h02);
        wait_mode(clk_mode_pkg::MODE_SLOW, 2000);
        repeat (10) @(posedge clk);
        check("hs off", hsRun, 0);
        bus(1, 8'h00, 32'h03);
        wait_mode(clk_mode_pkg::MODE_NORMAL, 6000);
        $display("slow test done");
        for (k = 0; k < 3; k++) begin
            bus(1, 8'h04, (k == 2) << 7);
            bus(1, 8'h00, 32'h01 | ((k != 0) << 1));
            pulse(1'b0);
            wait_mode(k == 0 ? clk_mode_pkg::MODE_SLEEP1 : k == 1 ? clk_mode_pkg::MODE_IDLE0
                : clk_mode_pkg::MODE_IDLE1, 10);
            repeat (8) @(posedge clk);
            count_ticks(200, i); check("halted cpu", i, 0);
            pulse(1'b1);
            wait_mode(clk_mode_pkg::MODE_NORMAL, 6000);
            count_ticks(5000, i);
            check("woke", i > 0, 1);
        end
        $display("halt test done");
        close_out;
    end
endmodule // test_system_clock_power_mode_ctrl
`default_nettype wire

// >>> rtl/clk_mode_pkg.sv
// constants, register map and types of the clock mode controller
// assumes a 32-bit wishbone slave, one word per register
package clk_mode_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SYSTEM_MODE_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_MODE_CONTROL_EXT = 8'h04;

    localparam logic [7:0] RST_SYSTEM_MODE_CONTROL     = 8'h03;
    localparam logic [7:0] RST_SYSTEM_MODE_CONTROL_EXT = 8'h00;

    // ------------------------------------------------------------
    // field positions, system_mode_control
    // ------------------------------------------------------------
    localparam int BIT_SYS_CLK_HIGH_SEL    = 0;
    localparam int BIT_IDLE_ON_HALT        = 1;
    localparam int BIT_HIGH_OSC_READY_FLAG = 2;
    localparam int BIT_LOW_OSC_READY_FLAG  = 3;
    localparam int BIT_FAST_WAKE_ENABLE    = 4;
    localparam int POS_CLK_DIVIDER_FIELD   = 5;
    localparam int WID_CLK_DIVIDER_FIELD   = 3;

    // ------------------------------------------------------------
    // field positions, system_mode_control_ext
    // ------------------------------------------------------------
    localparam int BIT_WDOG_CTRL_REG_RESET_FLAG = 0;
    localparam int BIT_VOLT_CTRL_REG_RESET_FLAG = 1;
    localparam int BIT_LOW_VOLT_RESET_FLAG      = 2;
    localparam int BIT_IDLE_SYSCLK_KEEP         = 7;

    // ------------------------------------------------------------
    // timing counts, in oscillator cycles
    // ------------------------------------------------------------
    localparam int HS_READY_CYCLES  = 1024;
    localparam int RC_WAKE_CYCLES   = 16;
    localparam int AUX_READY_CYCLES = 1024;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_IDLE0,
        MODE_IDLE1,
        MODE_SLEEP0,
        MODE_SLEEP1
    } op_mode_t;

    typedef enum {
        ST_RUN,
        ST_IDLE0,
        ST_IDLE1,
        ST_SLEEP1,
        ST_WAKE_WAIT,
        ST_WAKE_FAST
    } pm_state_t;

endpackage

// >>> rtl/clk_sel_if.sv
// carrier from the mode controller to the clock divider
// assumes both ends run on the same clk
`timescale 1ns/10ps
`default_nettype none

interface clk_sel_if;
    logic       hsTick;
    logic       auxTick;
    logic       selRun;
    logic       selAux;
    logic [2:0] selLog;
    logic       sysTick;

    modport ctrl (output hsTick, output auxTick, output selRun, output selAux,
                  output selLog, input sysTick);
    modport div  (input hsTick, input auxTick, input selRun, input selAux,
                  input selLog, output sysTick);
endinterface

`default_nettype wire

// >>> rtl/osc_ready_timer.sv
// counts ticks after a restart, ready at the target count
// assumes tick is a one-cycle pulse on clk, restart a level
`timescale 1ns/10ps
`default_nettype none

module osc_ready_timer #(
    parameter int CNT_W = 11
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // count control
    input  wire logic             restart,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] target,
    // status
    output logic                  ready
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cnt_q <= '0;
            ready <= 1'b0;
        end else if (tick && !ready) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q + 1'b1 == target) begin
                ready <= 1'b1;
            end
        end
    end
endmodule // osc_ready_timer

`default_nettype wire

// >>> rtl/sys_clk_divider.sv
// divides the selected source into system ticks
// assumes source ticks are one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none

module sys_clk_divider (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // selection and output
    clk_sel_if.div    sel
);
    logic       actAux_q;
    logic [2:0] actLog_q;
    logic [5:0] cnt_q;
    logic       srcTick;

    assign srcTick = actAux_q ? sel.auxTick : sel.hsTick;

    // selection loads while stopped or at a period end of the old source,
    // and the count restarts, so no runt period
    always_ff @(posedge clk) begin
        if (rst) begin
            actAux_q    <= 1'b0;
            actLog_q    <= 3'h0;
            cnt_q       <= 6'h00;
            sel.sysTick <= 1'b0;
        end else if (!sel.selRun) begin
            actAux_q    <= sel.selAux;
            actLog_q    <= sel.selLog;
            cnt_q       <= 6'h00;
            sel.sysTick <= 1'b0;
        end else if (srcTick) begin
            if (cnt_q == 6'((7'h01 << actLog_q) - 7'h01)) begin
                cnt_q       <= 6'h00;
                sel.sysTick <= 1'b1;
                actAux_q    <= sel.selAux;
                actLog_q    <= sel.selLog;
            end else begin
                cnt_q       <= cnt_q + 6'h01;
                sel.sysTick <= 1'b0;
            end
        end else begin
            sel.sysTick <= 1'b0;
        end
    end
endmodule // sys_clk_divider

`default_nettype wire

// >>> rtl/system_clock_power_mode_ctrl.sv
// system clock selection and power mode control, wishbone register slave
// assumes pins far slower than clk; halt and wake on clk
//
// Behaviour
// - high-speed source fixed by static configuration strap
// - aux clock feeds time base, watchdog, wake
// - select bit 1 gives undivided high-speed clock
// - divider 000/001 aux, else high/64 down to /2
// - normal mode divides high-speed clock by 1..64
// - switching to aux stops the high-speed oscillator
// - slow mode runs aux with high-speed off, except in fast wake, where high-speed runs
// - six modes with their clock on/off pattern
// - halt goes idle or sleep by idle_on_halt
// - sleep0 never entered; sleep means sleep1
// - sleep1 stops CPU, aux keeps running
// - idle0 stops CPU and system oscillator
// - idle1 stops CPU, system clock keeps peripherals
// - fast wake switches to high-speed after 1024
// - RC wake takes 16 cycles, fast wake ignored
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module system_clock_power_mode_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // oscillator pins and configuration strap
    input  wire logic              hsOscPin,
    input  wire logic              auxOscPin,
    input  wire logic              cfgHsSrcRc,
    // cpu core
    input  wire logic              haltReq,
    input  wire logic              wakeReq,
    // reset cause events
    input  wire logic              lowVoltEvent,
    input  wire logic              voltCtrlBadEvent,
    input  wire logic              wdogCtrlEvent,
    // clocks and status out
    output logic                   cpuClkEn_q,
    output logic                   periphClkEn_q,
    output logic                   auxClkEn_q,
    output logic                   hsOscRun_q,
    output clk_mode_pkg::op_mode_t mode_q
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    clk_sel_if             selBus ();
    clk_mode_pkg::pm_state_t state_q;

    logic [2:0] hsSync_q;
    logic [2:0] auxSync_q;
    logic       hsSrcRc_q;
    logic       sysClkHighSel_q;
    logic       idleOnHalt_q;
    logic       fastWakeEnable_q;
    logic [2:0] clkDividerField_q;
    logic       idleSysclkKeep_q;
    logic       lowVoltResetFlag_q;
    logic       voltCtrlRegResetFlag_q;
    logic       wdogCtrlRegResetFlag_q;
    logic       hsReady;
    logic       auxReady;
    logic [10:0] hsTarget;
    logic       cfgAux;
    logic       hsTick;
    logic       auxTick;
    logic       wbReq;
    logic       wrCtl;
    logic       wrExt;
    logic [7:0] ctlRead;
    logic [7:0] extRead;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // divider code 010..111 maps to 2^6..2^1
    function automatic logic [2:0] div_log(input logic [2:0] code);
        return 3'(4'h8 - {1'b0, code});
    endfunction

    function automatic logic is_aux_code(input logic [2:0] code);
        return code[2:1] == 2'h0;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and tick extraction
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            hsSync_q  <= 3'h0;
            auxSync_q <= 3'h0;
        end else begin
            hsSync_q  <= {hsSync_q[1:0], hsOscPin};
            auxSync_q <= {auxSync_q[1:0], auxOscPin};
        end
    end

    // a stopped oscillator gives no ticks
    assign hsTick  = hsOscRun_q && hsSync_q[1] && !hsSync_q[2];
    assign auxTick = auxSync_q[1] && !auxSync_q[2];

    // strap sampled during reset, then frozen
    always_ff @(posedge clk) begin
        if (rst) begin
            hsSrcRc_q <= cfgHsSrcRc;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign wbReq = wb_cyc_i && wb_stb_i;
    assign wrCtl = wbReq && wb_we_i && wb_ack_o && wb_sel_i[0]
                   && wb_adr_i == ADDR_W'(clk_mode_pkg::OFS_SYSTEM_MODE_CONTROL);
    assign wrExt = wbReq && wb_we_i && wb_ack_o && wb_sel_i[0]
                   && wb_adr_i == ADDR_W'(clk_mode_pkg::OFS_SYSTEM_MODE_CONTROL_EXT);

    always_comb begin
        ctlRead = 8'h00;
        ctlRead[clk_mode_pkg::POS_CLK_DIVIDER_FIELD +: clk_mode_pkg::WID_CLK_DIVIDER_FIELD]
            = clkDividerField_q;
        ctlRead[clk_mode_pkg::BIT_FAST_WAKE_ENABLE]    = fastWakeEnable_q;
        ctlRead[clk_mode_pkg::BIT_LOW_OSC_READY_FLAG]  = auxReady;
        ctlRead[clk_mode_pkg::BIT_HIGH_OSC_READY_FLAG] = hsReady;
        ctlRead[clk_mode_pkg::BIT_IDLE_ON_HALT]        = idleOnHalt_q;
        ctlRead[clk_mode_pkg::BIT_SYS_CLK_HIGH_SEL]    = sysClkHighSel_q;
        extRead = 8'h00;
        extRead[clk_mode_pkg::BIT_IDLE_SYSCLK_KEEP]         = idleSysclkKeep_q;
        extRead[clk_mode_pkg::BIT_LOW_VOLT_RESET_FLAG]      = lowVoltResetFlag_q;
        extRead[clk_mode_pkg::BIT_VOLT_CTRL_REG_RESET_FLAG] = voltCtrlRegResetFlag_q;
        extRead[clk_mode_pkg::BIT_WDOG_CTRL_REG_RESET_FLAG] = wdogCtrlRegResetFlag_q;
    end

    // one wait state; ack lasts one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq && !wb_ack_o;
            if (wbReq && !wb_ack_o) begin
                if (wb_adr_i == ADDR_W'(clk_mode_pkg::OFS_SYSTEM_MODE_CONTROL)) begin
                    wb_dat_o <= {24'h00_0000, ctlRead};
                end else if (wb_adr_i == ADDR_W'(clk_mode_pkg::OFS_SYSTEM_MODE_CONTROL_EXT)) begin
                    wb_dat_o <= {24'h00_0000, extRead};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            clkDividerField_q <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL[
                clk_mode_pkg::POS_CLK_DIVIDER_FIELD +: clk_mode_pkg::WID_CLK_DIVIDER_FIELD];
            fastWakeEnable_q  <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL[
                clk_mode_pkg::BIT_FAST_WAKE_ENABLE];
            idleOnHalt_q      <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL[
                clk_mode_pkg::BIT_IDLE_ON_HALT];
            sysClkHighSel_q   <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL[
                clk_mode_pkg::BIT_SYS_CLK_HIGH_SEL];
            idleSysclkKeep_q  <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL_EXT[
                clk_mode_pkg::BIT_IDLE_SYSCLK_KEEP];
        end else begin
            if (wrCtl) begin
                clkDividerField_q <= wb_dat_i[
                    clk_mode_pkg::POS_CLK_DIVIDER_FIELD +: clk_mode_pkg::WID_CLK_DIVIDER_FIELD];
                fastWakeEnable_q  <= wb_dat_i[clk_mode_pkg::BIT_FAST_WAKE_ENABLE];
                idleOnHalt_q      <= wb_dat_i[clk_mode_pkg::BIT_IDLE_ON_HALT];
                sysClkHighSel_q   <= wb_dat_i[clk_mode_pkg::BIT_SYS_CLK_HIGH_SEL];
            end
            if (wrExt) begin
                idleSysclkKeep_q <= wb_dat_i[clk_mode_pkg::BIT_IDLE_SYSCLK_KEEP];
            end
        end
    end

    // reset cause flags: software clears, a same-cycle event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            lowVoltResetFlag_q     <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL_EXT[
                clk_mode_pkg::BIT_LOW_VOLT_RESET_FLAG];
            voltCtrlRegResetFlag_q <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL_EXT[
                clk_mode_pkg::BIT_VOLT_CTRL_REG_RESET_FLAG];
            wdogCtrlRegResetFlag_q <= clk_mode_pkg::RST_SYSTEM_MODE_CONTROL_EXT[
                clk_mode_pkg::BIT_WDOG_CTRL_REG_RESET_FLAG];
        end else begin
            if (lowVoltEvent) begin
                lowVoltResetFlag_q <= 1'b1;
            end else if (wrExt && !wb_dat_i[clk_mode_pkg::BIT_LOW_VOLT_RESET_FLAG]) begin
                lowVoltResetFlag_q <= 1'b0;
            end
            if (voltCtrlBadEvent) begin
                voltCtrlRegResetFlag_q <= 1'b1;
            end else if (wrExt && !wb_dat_i[clk_mode_pkg::BIT_VOLT_CTRL_REG_RESET_FLAG]) begin
                voltCtrlRegResetFlag_q <= 1'b0;
            end
            if (wdogCtrlEvent) begin
                wdogCtrlRegResetFlag_q <= 1'b1;
            end else if (wrExt && !wb_dat_i[clk_mode_pkg::BIT_WDOG_CTRL_REG_RESET_FLAG]) begin
                wdogCtrlRegResetFlag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // power mode state machine
    // ------------------------------------------------------------
    assign cfgAux = !sysClkHighSel_q && is_aux_code(clkDividerField_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= clk_mode_pkg::ST_RUN;
        end else begin
            case (state_q)
                clk_mode_pkg::ST_RUN: begin
                    if (haltReq) begin
                        if (!idleOnHalt_q) begin
                            state_q <= clk_mode_pkg::ST_SLEEP1;
                        end else if (idleSysclkKeep_q) begin
                            state_q <= clk_mode_pkg::ST_IDLE1;
                        end else begin
                            state_q <= clk_mode_pkg::ST_IDLE0;
                        end
                    end
                end
                clk_mode_pkg::ST_IDLE1: begin
                    if (wakeReq) begin
                        state_q <= clk_mode_pkg::ST_RUN;
                    end
                end
                clk_mode_pkg::ST_IDLE0, clk_mode_pkg::ST_SLEEP1: begin
                    if (wakeReq) begin
                        if (cfgAux) begin
                            state_q <= clk_mode_pkg::ST_RUN;
                        end else if (fastWakeEnable_q && !hsSrcRc_q) begin
                            state_q <= clk_mode_pkg::ST_WAKE_FAST;
                        end else begin
                            state_q <= clk_mode_pkg::ST_WAKE_WAIT;
                        end
                    end
                end
                clk_mode_pkg::ST_WAKE_WAIT, clk_mode_pkg::ST_WAKE_FAST: begin
                    if (hsReady) begin
                        state_q <= clk_mode_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_q <= clk_mode_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // oscillator readiness
    // ------------------------------------------------------------
    // RC restarts in 16 of its cycles, the crystal in 1024
    assign hsTarget = hsSrcRc_q ? 11'(clk_mode_pkg::RC_WAKE_CYCLES)
                                : 11'(clk_mode_pkg::HS_READY_CYCLES);

    osc_ready_timer #(.CNT_W(11)) hsTimer (
        .clk     (clk),
        .rst     (rst),
        .restart (!hsOscRun_q),
        .tick    (hsTick),
        .target  (hsTarget),
        .ready   (hsReady)
    );

    // aux never stops, so its flag waits only after power-on
    osc_ready_timer #(.CNT_W(11)) auxTimer (
        .clk     (clk),
        .rst     (rst),
        .restart (1'b0),
        .tick    (auxTick),
        .target  (11'(clk_mode_pkg::AUX_READY_CYCLES)),
        .ready   (auxReady)
    );

    // ------------------------------------------------------------
    // system clock selection
    // ------------------------------------------------------------
    assign selBus.hsTick  = hsTick;
    assign selBus.auxTick = auxTick;
    assign selBus.selRun  = state_q == clk_mode_pkg::ST_RUN
                            || state_q == clk_mode_pkg::ST_IDLE1
                            || state_q == clk_mode_pkg::ST_WAKE_FAST;
    assign selBus.selAux  = cfgAux || state_q == clk_mode_pkg::ST_WAKE_FAST;
    assign selBus.selLog  = sysClkHighSel_q ? 3'h0
                                            : div_log(clkDividerField_q);

    sys_clk_divider divider (
        .clk (clk),
        .rst (rst),
        .sel (selBus.div)
    );

    // ------------------------------------------------------------
    // clock enables, oscillator run and mode report
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cpuClkEn_q    <= 1'b0;
            periphClkEn_q <= 1'b0;
            auxClkEn_q    <= 1'b0;
        end else begin
            cpuClkEn_q    <= selBus.sysTick && (state_q == clk_mode_pkg::ST_RUN
                             || state_q == clk_mode_pkg::ST_WAKE_FAST);
            periphClkEn_q <= selBus.sysTick && (state_q == clk_mode_pkg::ST_RUN
                             || state_q == clk_mode_pkg::ST_WAKE_FAST
                             || state_q == clk_mode_pkg::ST_IDLE1);
            auxClkEn_q    <= auxTick;
        end
    end

    // hs oscillator off while unused
    always_ff @(posedge clk) begin
        if (rst) begin
            hsOscRun_q <= 1'b1;
        end else begin
            case (state_q)
                clk_mode_pkg::ST_RUN, clk_mode_pkg::ST_IDLE1: begin
                    hsOscRun_q <= !cfgAux;
                end
                clk_mode_pkg::ST_WAKE_WAIT, clk_mode_pkg::ST_WAKE_FAST: begin
                    hsOscRun_q <= 1'b1;
                end
                default: begin
                    hsOscRun_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= clk_mode_pkg::MODE_NORMAL;
        end else begin
            case (state_q)
                clk_mode_pkg::ST_IDLE0:  mode_q <= clk_mode_pkg::MODE_IDLE0;
                clk_mode_pkg::ST_IDLE1:  mode_q <= clk_mode_pkg::MODE_IDLE1;
                clk_mode_pkg::ST_SLEEP1: mode_q <= clk_mode_pkg::MODE_SLEEP1;
                clk_mode_pkg::ST_WAKE_FAST: mode_q <= clk_mode_pkg::MODE_SLOW;
                default: begin
                    mode_q <= cfgAux ? clk_mode_pkg::MODE_SLOW : clk_mode_pkg::MODE_NORMAL;
                end
            endcase
        end
    end
endmodule // system_clock_power_mode_ctrl

`default_nettype wire
